// [rtl/ipcs_top.sv]
// I2C port control and status: control registers, flags, pin takeover, clock stretch.
// Assumes one AHB-Lite master, single word transfers; the bit engine drives link inputs.
`timescale 1ns/1ps
`default_nettype none
module ipcs_top
  import ipcs_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire ipcs_link_s  link,
  output logic             port_owns_pins,
  output logic             scl_hold_low,
  output logic             brg_tick,
  output logic             tx_load,
  output logic      [7:0]  tx_byte,
  output logic             addr_10bit,
  output logic             target_active,
  output logic             controller_active,
  output logic      [7:0]  ctrl2_out,
  output logic             irq
);

  ipcs_state_s s_r;
  ipcs_state_s s_nxt;

  logic       wr_fire;
  logic       rd_fire;
  logic [7:0] wbyte;
  logic       tgt_mode;
  logic       ss_irq;
  logic       ctl_mode;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  always_comb begin
    tgt_mode = 1'b0;
    ss_irq   = 1'b0;
    ctl_mode = 1'b0;
    unique case (s_r.ctrl1_r[3:0])
      M_TGT10_SS, M_TGT7_SS: begin
        tgt_mode = 1'b1;
        ss_irq   = 1'b1;
      end
      M_TGT10, M_TGT7: begin
        tgt_mode = 1'b1;
      end
      M_CTL, M_FWCTL: begin
        ctl_mode = 1'b1;
      end
      default: begin
        tgt_mode = 1'b0; // Other codes leave the port idle
      end
    endcase
  end

  assign wr_fire = s_r.sel_r & s_r.wr_r;
  assign rd_fire = hsel & hready & htrans[1] & ~hwrite;
  assign wbyte   = hwdata[7:0];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt            = s_r;
    s_nxt.sel_r      = hsel & hready & htrans[1];
    s_nxt.wr_r       = hwrite;
    s_nxt.addr_r     = haddr[7:0];
    s_nxt.tx_load_r  = 1'b0;
    s_nxt.brg_tick_r = 1'b0;

    // Role follows enable and mode
    if (!s_r.ctrl1_r[B_EN]) begin
      s_nxt.role_r = IPCS_OFF;
    end else if (tgt_mode) begin
      s_nxt.role_r = IPCS_TGT;
    end else if (s_r.ctrl1_r[3:0] == M_FWCTL) begin
      s_nxt.role_r = IPCS_FWCTL;
    end else if (ctl_mode) begin
      s_nxt.role_r = IPCS_CTL;
    end else begin
      s_nxt.role_r = IPCS_OFF;
    end

    // Baud generator: one tick every 4*(reload[6:0]+1) clocks
    if (s_r.role_r == IPCS_CTL) begin
      s_nxt.div_cnt_r = s_r.div_cnt_r + 2'h1;
      if (s_r.div_cnt_r == CLK_DIV) begin
        if (s_r.brg_cnt_r == 7'h00) begin
          s_nxt.brg_cnt_r  = s_r.reload_r[6:0];
          s_nxt.brg_tick_r = 1'b1;
        end else begin
          s_nxt.brg_cnt_r = s_r.brg_cnt_r - 7'h01;
        end
      end
    end else begin
      s_nxt.div_cnt_r = 2'h0;
      s_nxt.brg_cnt_r = s_r.reload_r[6:0];
    end

    // Register writes in data phase
    if (wr_fire) begin
      unique case (s_r.addr_r)
        OFS_CTRL1: begin
          // Flags can only be cleared by software, never set by it
          s_nxt.ctrl1_r[5:0] = wbyte[5:0];
          s_nxt.ctrl1_r[B_WRITE_COLLISION_FLAG] = s_r.ctrl1_r[B_WRITE_COLLISION_FLAG] & wbyte[B_WRITE_COLLISION_FLAG];
          s_nxt.ctrl1_r[B_OV]   = s_r.ctrl1_r[B_OV] & wbyte[B_OV];
        end
        OFS_CTRL2:  s_nxt.ctrl2_r = wbyte;
        OFS_RELOAD: s_nxt.reload_r = wbyte;
        OFS_BUF: begin
          if ((s_r.role_r == IPCS_CTL || s_r.role_r == IPCS_FWCTL) && link.bus_busy
              && !link.rx_mode) begin
            s_nxt.ctrl1_r[B_WRITE_COLLISION_FLAG] = 1'b1;
            s_nxt.stat_r[I_WRITE_COLLISION_FLAG]  = 1'b1;
          end else if (s_r.role_r == IPCS_TGT && link.shifting && !link.rx_mode) begin
            s_nxt.ctrl1_r[B_WRITE_COLLISION_FLAG] = 1'b1;
            s_nxt.stat_r[I_WRITE_COLLISION_FLAG]  = 1'b1;
          end else begin
            s_nxt.buf_r     = wbyte;
            s_nxt.shift_r   = wbyte;
            // A transmit byte is never an unread received byte, so it must not
            // arm the overflow check of a later reception
            s_nxt.full_r    = 1'b0;
            s_nxt.tx_load_r = 1'b1;
          end
        end
        OFS_STAT: s_nxt.stat_r = s_r.stat_r & ~wbyte[N_IRQ-1:0];
        OFS_MASK: s_nxt.mask_r = wbyte[N_IRQ-1:0];
        default:  s_nxt.mask_r = s_r.mask_r;
      endcase
    end

    // Reading the buffer empties it
    if (rd_fire && haddr[7:0] == OFS_BUF) begin
      s_nxt.full_r = 1'b0;
    end

    // Events from the link; sets placed after clears so sets win
    if (s_r.role_r != IPCS_OFF) begin
      if (link.rx_done) begin
        if (s_r.full_r && link.rx_mode) begin
          s_nxt.ctrl1_r[B_OV] = 1'b1;
          s_nxt.stat_r[I_OV]  = 1'b1;
        end else begin
          s_nxt.buf_r  = link.rx_byte;
          s_nxt.full_r = 1'b1;
        end
        s_nxt.stat_r[I_BYTE] = 1'b1;
      end
      if (ss_irq && link.start_seen) begin
        s_nxt.stat_r[I_START] = 1'b1;
      end
      if (ss_irq && link.stop_seen) begin
        s_nxt.stat_r[I_STOP] = 1'b1;
      end
    end

    // Read data register
    s_nxt.hrdata_r = 32'h0000_0000;
    if (rd_fire) begin
      unique case (haddr[7:0])
        OFS_CTRL1:  s_nxt.hrdata_r[7:0] = s_r.ctrl1_r; // WRITE_COLLISION_FLAG value is don't-care in rx
        OFS_CTRL2:  s_nxt.hrdata_r[7:0] = s_r.ctrl2_r;
        OFS_BUF:    s_nxt.hrdata_r[7:0] = s_r.buf_r;
        OFS_RELOAD: s_nxt.hrdata_r[7:0] = s_r.reload_r;
        OFS_STAT:   s_nxt.hrdata_r[N_IRQ-1:0] = s_r.stat_r;
        OFS_MASK:   s_nxt.hrdata_r[N_IRQ-1:0] = s_r.mask_r;
        default:    s_nxt.hrdata_r = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '{ctrl1_r: CTRL1_RST, ctrl2_r: CTRL2_RST, buf_r: 8'h00, shift_r: 8'h00,
               full_r: 1'b0, reload_r: RELOAD_RST, stat_r: '0, mask_r: '0,
               brg_cnt_r: 7'h00, div_cnt_r: 2'h0, brg_tick_r: 1'b0, tx_load_r: 1'b0,
               sel_r: 1'b0, wr_r: 1'b0, addr_r: 8'h00, hrdata_r: 32'h0000_0000,
               role_r: IPCS_OFF};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata            = s_r.hrdata_r;
  assign hreadyout         = 1'b1;
  assign hresp             = 1'b0;
  assign port_owns_pins    = (s_r.role_r != IPCS_OFF);
  assign scl_hold_low      = (s_r.role_r == IPCS_TGT) & ~s_r.ctrl1_r[B_CKREL];
  assign brg_tick          = s_r.brg_tick_r;
  assign tx_load           = s_r.tx_load_r;
  assign tx_byte           = s_r.shift_r;
  assign addr_10bit        = s_r.ctrl1_r[0] & (s_r.role_r == IPCS_TGT);
  assign target_active     = (s_r.role_r == IPCS_TGT);
  assign controller_active = (s_r.role_r == IPCS_CTL);
  assign ctrl2_out         = s_r.ctrl2_r;
  assign irq               = |(s_r.stat_r & s_r.mask_r);

endmodule : ipcs_top
`default_nettype wire

// [rtl/ipcs_pkg.sv]
// Package for the I2C port control and status block: register map, fields, modes.
// Assumes an AHB-Lite slave with 32-bit data, one register per aligned word.
package ipcs_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL1  = 8'h00;
  localparam logic [7:0] OFS_CTRL2  = 8'h04;
  localparam logic [7:0] OFS_BUF    = 8'h08;
  localparam logic [7:0] OFS_RELOAD = 8'h0C;
  localparam logic [7:0] OFS_STAT   = 8'h10;
  localparam logic [7:0] OFS_MASK   = 8'h14;

  // ----------------------------------------------------------------
  // Control one fields and reset values
  // ----------------------------------------------------------------
  localparam int          B_WRITE_COLLISION_FLAG  = 7;
  localparam int          B_OV    = 6;
  localparam int          B_EN    = 5;
  localparam int          B_CKREL = 4;
  localparam logic [7:0]  CTRL1_RST  = 8'h00;
  localparam logic [7:0]  CTRL2_RST  = 8'h00;
  localparam logic [7:0]  RELOAD_RST = 8'h00;
  localparam logic [1:0]  CLK_DIV    = 2'h3;

  // Interrupt status bits
  localparam int I_BYTE  = 0;
  localparam int I_START = 1;
  localparam int I_STOP  = 2;
  localparam int I_WRITE_COLLISION_FLAG  = 3;
  localparam int I_OV    = 4;
  localparam int N_IRQ   = 5;

  // ----------------------------------------------------------------
  // Mode codes
  // ----------------------------------------------------------------
  localparam logic [3:0] M_TGT10_SS = 4'hF;
  localparam logic [3:0] M_TGT7_SS  = 4'hE;
  localparam logic [3:0] M_FWCTL    = 4'hB;
  localparam logic [3:0] M_CTL      = 4'h8;
  localparam logic [3:0] M_TGT10    = 4'h7;
  localparam logic [3:0] M_TGT7     = 4'h6;

  typedef enum logic [3:0] {
    IPCS_OFF   = 4'b0001,
    IPCS_TGT   = 4'b0010,
    IPCS_CTL   = 4'b0100,
    IPCS_FWCTL = 4'b1000
  } ipcs_role_e;

  typedef struct packed {
    logic       rx_done;
    logic [7:0] rx_byte;
    logic       start_seen;
    logic       stop_seen;
    logic       shifting;
    logic       bus_busy;
    logic       rx_mode;
  } ipcs_link_s;

  typedef struct packed {
    logic [7:0]         ctrl1_r;
    logic [7:0]         ctrl2_r;
    logic [7:0]         buf_r;
    logic [7:0]         shift_r;
    logic               full_r;
    logic [7:0]         reload_r;
    logic [N_IRQ-1:0]   stat_r;
    logic [N_IRQ-1:0]   mask_r;
    logic [6:0]         brg_cnt_r;
    logic [1:0]         div_cnt_r;
    logic               brg_tick_r;
    logic               tx_load_r;
    logic               sel_r;
    logic               wr_r;
    logic [7:0]         addr_r;
    logic [31:0]        hrdata_r;
    ipcs_role_e         role_r;
  } ipcs_state_s;

endpackage : ipcs_pkg

// [verif/ipcs_top_checker.sv]
// Concurrent checks on the port control block, seen from its top ports.
// Assumes a bind into ipcs_top and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ipcs_top_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        scl_hold_low,
  input wire logic        brg_tick,
  input wire logic        addr_10bit,
  input wire logic        target_active,
  input wire logic        controller_active,
  input wire logic        port_owns_pins
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence quiet3;
    !brg_tick [*3];
  endsequence
  ok_resp_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  upper_zero_a: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  hold_tgt_a: assert property (scl_hold_low |-> target_active)
    else $error("clock held low outside target role");
  role_excl_a: assert property (!(target_active && controller_active))
    else $error("target and controller both active");
  owns_pins_a: assert property (target_active || controller_active |-> port_owns_pins)
    else $error("role active without pins");
  a10_tgt_a: assert property (addr_10bit |-> target_active)
    else $error("long address outside target role");
  brg_ctl_a: assert property (brg_tick |-> controller_active || $past(controller_active))
    else $error("baud tick outside controller role");
  brg_gap_a: assert property (brg_tick |=> quiet3)
    else $error("baud ticks closer than four cycles");
endmodule // ipcs_top_checker
bind ipcs_top ipcs_top_checker ipcs_top_checker_i (.hclk, .hresetn, .hrdata, .hreadyout,
  .hresp, .scl_hold_low, .brg_tick, .addr_10bit, .target_active, .controller_active,
  .port_owns_pins);
`default_nettype wire

// [verif/ipcs_link_model.sv]
// Bit engine stand-in: turns bench requests into link events.
// Assumes the block's clock; requests change just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module ipcs_link_model
  import ipcs_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       busy,
  input  wire logic       shift,
  input  wire logic       rxm,
  input  wire logic       send,
  input  wire logic [7:0] byte_in,
  output ipcs_link_s      link
);
  logic [1:0] ph_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ph_r <= 2'h0;
    else ph_r <= {ph_r[0], send};
  end
  // Byte lines show the inverse outside the done pulse
  assign link = '{rx_done: ph_r[1], rx_byte: ph_r[1] ? byte_in : ~byte_in,
                  start_seen: ph_r[0], stop_seen: ph_r[1], shifting: shift,
                  bus_busy: busy, rx_mode: rxm};
endmodule // ipcs_link_model
`default_nettype wire

// [verif/ipcs_top_tb_top.sv]
// Self-checking bench: registers, modes, pins, stretch, baud, flags, irq.
// Assumes ipcs_top with the link model as bit engine and the checker bound in.
`timescale 1ns/1ps
`default_nettype none
module ipcs_top_tb_top;
  import ipcs_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, busy, shift, send, rxm;
  logic        hreadyout, hresp, owns, hold, brg, tx_load, a10, tgt, ctl, irq;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  byte_in, tx_byte, ctrl2_out;
  ipcs_link_s  link;
  int          n_mismatch, comparisons, n_load;
  ipcs_top ipcs_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .link, .port_owns_pins(owns),
    .scl_hold_low(hold), .brg_tick(brg), .tx_load, .tx_byte, .addr_10bit(a10),
    .target_active(tgt), .controller_active(ctl), .ctrl2_out, .irq);
  ipcs_link_model ipcs_link_model_i (.hclk, .hresetn, .busy, .shift, .rxm, .send, .byte_in,
    .link);
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) if (tx_load === 1'b1) n_load <= n_load + 1;
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic tmo(input int n);
    if (n > 200) begin
      n_mismatch++;
      close_out();
    end
  endtask
  task automatic wt;
    int n;
    n = 0;
    do begin
      cyc(1);
      tmo(n++);
    end while (hreadyout !== 1'b1);
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    wt();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    wt();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic give(input logic [7:0] b);
    byte_in <= b;
    send    <= 1'b1;
    cyc(1);
    send    <= 1'b0;
    cyc(5);
  endtask
  task automatic t_reset;
    logic [7:0] ofs [7] = '{OFS_CTRL1, OFS_CTRL2, OFS_BUF, OFS_RELOAD, OFS_STAT, OFS_MASK, 8'h18};
    foreach (ofs[i]) rdc("reset value", ofs[i], 32'h0);
    wr(OFS_CTRL2, 32'h5A);
    wr(8'h18, 32'hFF);
    rdc("unmapped", 8'h18, 32'h0);
    rdc("ctrl2", OFS_CTRL2, 32'h5A);
    chk("ctrl2_out", 32'h5A, {24'h0, ctrl2_out});
    $display("test reset done");
  endtask
  task automatic t_modes;
    logic [3:0] code [7] = '{M_TGT10_SS, M_TGT7_SS, M_FWCTL, M_CTL, M_TGT10, M_TGT7, 4'h3};
    logic [3:0] e [7] = '{4'hB, 4'h9, 4'h1, 4'h5, 4'hB, 4'h9, 4'h0};
    foreach (code[i]) begin
      wr(OFS_CTRL1, {28'h1, code[i]});
      wr(OFS_CTRL1, {28'h3, code[i]});
      cyc(2);
      chk("role", {28'h0, e[i]}, {28'h0, tgt, ctl, a10, owns});
    end
    wr(OFS_CTRL1, 32'h16);
    cyc(2);
    chk("role", 32'h0, {28'h0, tgt, ctl, a10, owns});
    $display("test modes done");
  endtask
  task automatic t_stretch;
    logic [7:0] v [3] = '{8'h26, 8'h36, 8'h28};
    logic       e [3] = '{1'b1, 1'b0, 1'b0};
    foreach (v[i]) begin
      wr(OFS_CTRL1, {24'h0, v[i]});
      cyc(2);
      chk("scl hold", {31'h0, e[i]}, {31'h0, hold});
    end
    $display("test stretch done");
  endtask
  task automatic til_brg(output int n);
    n = 0;
    do begin
      cyc(1);
      tmo(n++);
    end while (brg !== 1'b1);
  endtask
  task automatic t_brg;
    int n;
    wr(OFS_RELOAD, 32'h82);
    wr(OFS_CTRL1, 32'h38);
    til_brg(n);
    til_brg(n);
    chk("baud period", 32'd12, n);
    $display("test baud done");
  endtask
  task automatic t_write_collision_flag;
    int n0;
    wr(OFS_MASK, 32'h1F);
    busy <= 1'b1;
    n0 = n_load;
    wr(OFS_BUF, 32'hA5);
    cyc(3);
    chk("tx loads", n0, n_load);
    rdc("ctrl1", OFS_CTRL1, 32'hB8);
    chk("irq", 32'h1, {31'h0, irq});
    wr(OFS_CTRL1, 32'hB8);
    rdc("ctrl1", OFS_CTRL1, 32'hB8);
    wr(OFS_CTRL1, 32'h38);
    rdc("ctrl1", OFS_CTRL1, 32'h38);
    rdc("stat", OFS_STAT, 32'h08);
    wr(OFS_STAT, 32'h1F);
    busy <= 1'b0;
    rdc("stat", OFS_STAT, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    wr(OFS_BUF, 32'h5A);
    cyc(3);
    chk("tx loads", n0 + 1, n_load);
    chk("tx byte", 32'h5A, {24'h0, tx_byte});
    wr(OFS_CTRL1, 32'h36);
    shift <= 1'b1;
    wr(OFS_BUF, 32'h77);
    shift <= 1'b0;
    rdc("ctrl1", OFS_CTRL1, 32'hB6);
    $display("test collision done");
  endtask
  task automatic t_rx;
    wr(OFS_CTRL1, 32'h3E);
    wr(OFS_STAT, 32'h1F);
    rxm <= 1'b1;
    give(8'h3C);
    rdc("stat", OFS_STAT, 32'h07);
    rdc("buffer", OFS_BUF, 32'h3C);
    wr(OFS_STAT, 32'h1F);
    wr(OFS_CTRL1, 32'h36);
    give(8'h11);
    give(8'h22);
    rdc("ctrl1", OFS_CTRL1, 32'h76);
    rdc("buffer", OFS_BUF, 32'h11);
    rdc("stat", OFS_STAT, 32'h11);
    wr(OFS_MASK, 32'h0);
    cyc(2);
    chk("irq", 32'h0, {31'h0, irq});
    wr(OFS_MASK, 32'h10);
    cyc(2);
    chk("irq", 32'h1, {31'h0, irq});
    wr(OFS_STAT, 32'h1F);
    cyc(2);
    chk("irq", 32'h0, {31'h0, irq});
    rxm <= 1'b0;
    $display("test receive done");
  endtask
  initial begin
    {hresetn, hsel, hwrite, busy, shift, send, rxm} = '0;
    haddr = '0;
    hwdata = '0;
    htrans = '0;
    hsize = 3'h2;
    byte_in = '0;
    n_mismatch = 0;
    comparisons = 0;
    n_load = 0;
    cyc(6);
    hresetn <= 1'b1;
    cyc(1);
    t_reset();
    t_modes();
    t_stretch();
    t_brg();
    t_write_collision_flag();
    t_rx();
    close_out();
  end
endmodule // ipcs_top_tb_top
`default_nettype wire
